// >>> rtl/pwd_decode.sv
// register-space decoder: window selects, own registers, converter channel routing
// assumes one clock, synchronous bus strobes, peripherals answering reads combinationally from the bus address
//
// Functional notes
// R1: unallocated space: writes ignored, reads zero
// R2: part id high 0x001A, low 0x001B, read-only
// R3: wrap setting limits second converter to channels 0-7
// R4: third async window on largest and middle dies
// R5: fourth async window on largest die only
// R6: fifth async window on largest and middle dies
// R7: sixth async window on largest die only
// R8: third sync window on largest and middle dies
// R9: port integration window decoded on every die
// R10: dual converter: first PAD7-0, second PAD23-8
// R11: single converter: second on PAD15-0, first absent
// R12: masters avoid reserved locations
// R13: at most one select, none outside windows
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module pwd_decode #(
	parameter logic [15:0] ID_LARGE = 16'h5a01, // arbitrary value
	parameter logic [15:0] ID_MID   = 16'h5a02, // arbitrary value
	parameter logic [15:0] ID_SMALL = 16'h5a03  // arbitrary value
) (
	input  logic                                             clk,
	input  logic                                             rst_n,
	input  logic [1:0]                                       die_strap,
	input  pwd_pkg::pwd_req_t                                bus,
	input  logic [pwd_pkg::NUM_WIN-1:0][pwd_pkg::DATA_W-1:0] periph_rdata,
	input  logic                                             first_conv_step,
	input  logic                                             second_conv_step,
	output logic [pwd_pkg::DATA_W-1:0]                       rdata,
	output pwd_pkg::pwd_fwd_t                                fwd,
	output logic                                             first_conv_en,
	output logic [pwd_pkg::PAD_W-1:0]                        first_conv_pad,
	output logic [pwd_pkg::PAD_W-1:0]                        second_conv_pad,
	output logic [1:0]                                       die_code
);

	pwd_pkg::pwd_die_t                die;
	logic                             die_valid;
	logic [pwd_pkg::NUM_WIN-1:0]      hit;
	logic                             dual;
	logic [15:0]                      part_id;
	logic                             own_hit;
	logic                             cfg_wr;
	logic [pwd_pkg::DATA_W-1:0]       conv_cfg;
	logic [pwd_pkg::CH_W-1:0]         first_ch;
	logic [pwd_pkg::CH_W-1:0]         second_ch;
	logic [pwd_pkg::CH_W-1:0]         next_first_ch;
	logic [pwd_pkg::CH_W-1:0]         next_second_ch;
	logic [pwd_pkg::CH_W-1:0]         second_last;
	logic [pwd_pkg::PAD_W-1:0]        second_base;
	logic [pwd_pkg::OFS_W-1:0]        next_offset;
	logic [pwd_pkg::DATA_W-1:0]       next_rdata;
	logic [pwd_pkg::DATA_W-1:0]       decode_stat;

	// die strap caught once, right after reset release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			die       <= pwd_pkg::PWD_DIE_LARGE;
			die_valid <= 1'b0;
		end else if (!die_valid) begin
			die       <= pwd_pkg::pwd_die_t'(die_strap);
			die_valid <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			die_code <= 2'h0;
		end else begin
			die_code <= die;
		end
	end

	assign dual = (die != pwd_pkg::PWD_DIE_SMALL);

	always_comb begin
		case (die)
			pwd_pkg::PWD_DIE_LARGE: part_id = ID_LARGE;
			pwd_pkg::PWD_DIE_MID:   part_id = ID_MID;
			pwd_pkg::PWD_DIE_SMALL: part_id = ID_SMALL;
			default:                part_id = ID_LARGE;
		endcase
	end

	pwd_window_match u_match (
		.addr (bus.addr),
		.die  (die),
		.hit  (hit)
	);

	assign own_hit = (bus.addr == pwd_pkg::PART_ID_HIGH_OFS) || (bus.addr == pwd_pkg::PART_ID_LOW_OFS) ||
		(bus.addr == pwd_pkg::CONV_CFG_OFS) || (bus.addr == pwd_pkg::DECODE_STAT_OFS);

	// offset within the hit window
	always_comb begin
		next_offset = '0;
		for (int i = 0; i < pwd_pkg::NUM_WIN; i++) begin
			if (hit[i]) begin
				next_offset = pwd_pkg::OFS_W'(bus.addr - pwd_pkg::WIN_LO[i]);
			end
		end
	end

	// forwarded access toward the selected peripheral, one cycle after the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fwd <= '0;
		end else begin
			fwd.sel    <= (bus.wr || bus.rd) ? hit : '0; // R1 R13
			fwd.wr     <= bus.wr && (|hit); // R1
			fwd.rd     <= bus.rd && (|hit);
			fwd.offset <= next_offset;
			fwd.wdata  <= bus.wdata;
		end
	end

	// converter configuration, wrap bit only
	assign cfg_wr = bus.wr && (bus.addr == pwd_pkg::CONV_CFG_OFS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_cfg <= pwd_pkg::CONV_CFG_RESET;
		end else if (cfg_wr) begin
			conv_cfg <= bus.wdata & pwd_pkg::CONV_CFG_MASK;
		end
	end

	assign decode_stat = {second_ch, 1'b0, dual, die};

	// read mux: own registers, populated windows, zero elsewhere
	always_comb begin
		next_rdata = '0;
		if (bus.rd) begin
			if (bus.addr == pwd_pkg::PART_ID_HIGH_OFS) begin
				next_rdata = part_id[15:8]; // R2
			end else if (bus.addr == pwd_pkg::PART_ID_LOW_OFS) begin
				next_rdata = part_id[7:0]; // R2
			end else if (bus.addr == pwd_pkg::CONV_CFG_OFS) begin
				next_rdata = conv_cfg;
			end else if (bus.addr == pwd_pkg::DECODE_STAT_OFS) begin
				next_rdata = decode_stat;
			end else begin
				for (int i = 0; i < pwd_pkg::NUM_WIN; i++) begin
					if (hit[i]) begin
						next_rdata = periph_rdata[i];
					end
				end
			end
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata; // R1
		end
	end

	// first converter channel sequence, present on dual-converter dies only
	always_comb begin
		next_first_ch = first_ch;
		if (!dual) begin
			next_first_ch = '0; // R11
		end else if (first_conv_step) begin
			next_first_ch = pwd_pkg::next_ch(first_ch, pwd_pkg::FIRST_LAST_CH); // R10
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			first_ch       <= '0;
			first_conv_pad <= '0;
			first_conv_en  <= 1'b0;
		end else begin
			first_ch       <= next_first_ch;
			first_conv_pad <= {1'b0, next_first_ch}; // R10
			first_conv_en  <= dual; // R11
		end
	end

	// second converter channel sequence, wrap setting folds it to eight channels
	assign second_last = conv_cfg[pwd_pkg::CFG_WRAP_BIT] ? pwd_pkg::WRAP_LAST_CH : pwd_pkg::FULL_LAST_CH; // R3
	assign second_base = dual ? pwd_pkg::SECOND_BASE_DUAL : pwd_pkg::SECOND_BASE_ONE; // R10 R11

	always_comb begin
		next_second_ch = second_ch;
		if (cfg_wr) begin
			next_second_ch = '0;
		end else if (second_conv_step) begin
			next_second_ch = pwd_pkg::next_ch(second_ch, second_last); // R3
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			second_ch       <= '0;
			second_conv_pad <= '0;
		end else begin
			second_ch       <= next_second_ch;
			second_conv_pad <= pwd_pkg::PAD_W'(second_base + {1'b0, next_second_ch}); // R10 R11
		end
	end

	// checks
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	unalloc_read_zero_a: assert property (bus.rd && (hit == '0) && !own_hit |=> rdata == '0) // R1
		else $error("read of unallocated space returned nonzero");
	unalloc_write_drop_a: assert property (bus.wr && (hit == '0) |=> (fwd.sel == '0) && !fwd.wr) // R1
		else $error("write to unallocated space was forwarded");
	part_id_high_a: assert property (bus.rd && (bus.addr == pwd_pkg::PART_ID_HIGH_OFS)
		|=> rdata == part_id[15:8]) // R2
		else $error("part id high byte wrong");
	part_id_write_a: assert property (bus.wr && (bus.addr == pwd_pkg::PART_ID_LOW_OFS)
		##1 bus.rd && (bus.addr == pwd_pkg::PART_ID_LOW_OFS) |=> rdata == part_id[7:0]) // R2
		else $error("write changed part id low byte");
	wrap_limit_a: assert property (conv_cfg[pwd_pkg::CFG_WRAP_BIT] && second_conv_step && !cfg_wr &&
		(second_ch == 4'h7) |=> second_ch == 4'h0) // R3
		else $error("wrapped sequence passed channel seven");
	async_third_a: assert property ((bus.rd || bus.wr) && pwd_pkg::in_range(bus.addr, 11'h0b8, 11'h0bf)
		|=> fwd.sel[pwd_pkg::WIN_ASYNC3] == $past(die != pwd_pkg::PWD_DIE_SMALL)) // R4
		else $error("third async window decode wrong for die");
	async_fourth_a: assert property ((bus.rd || bus.wr) && pwd_pkg::in_range(bus.addr, 11'h0c0, 11'h0c7)
		|=> fwd.sel[pwd_pkg::WIN_ASYNC4] == $past(die == pwd_pkg::PWD_DIE_LARGE)) // R5
		else $error("fourth async window decode wrong for die");
	async_fifth_a: assert property ((bus.rd || bus.wr) && pwd_pkg::in_range(bus.addr, 11'h130, 11'h137)
		|=> fwd.sel[pwd_pkg::WIN_ASYNC5] == $past(die != pwd_pkg::PWD_DIE_SMALL)) // R6
		else $error("fifth async window decode wrong for die");
	async_sixth_a: assert property ((bus.rd || bus.wr) && pwd_pkg::in_range(bus.addr, 11'h138, 11'h13f)
		|=> fwd.sel[pwd_pkg::WIN_ASYNC6] == $past(die == pwd_pkg::PWD_DIE_LARGE)) // R7
		else $error("sixth async window decode wrong for die");
	sync_third_a: assert property ((bus.rd || bus.wr) && pwd_pkg::in_range(bus.addr, 11'h0f8, 11'h0ff)
		|=> fwd.sel[pwd_pkg::WIN_SYNC3] == $past(die != pwd_pkg::PWD_DIE_SMALL)) // R8
		else $error("third sync window decode wrong for die");
	port_integ_a: assert property (bus.wr && pwd_pkg::in_range(bus.addr, 11'h240, 11'h27f)
		|=> fwd.sel[pwd_pkg::WIN_PORT_INTEG] && fwd.wr && (fwd.offset == $past(bus.addr[5:0]))) // R9
		else $error("port integration window not decoded");
	dual_route_a: assert property (die_valid && dual && second_conv_step && !cfg_wr &&
		!conv_cfg[pwd_pkg::CFG_WRAP_BIT] && (second_ch == 4'hf) |=> second_conv_pad == 5'h08) // R10
		else $error("second converter not on upper pads");
	single_route_a: assert property (die_valid && !dual |=> !first_conv_en && (second_conv_pad <= 5'h0f)
		&& !fwd.sel[pwd_pkg::WIN_FIRST_CONV]) // R11
		else $error("single converter routing wrong");
	one_select_a: assert property ($onehot0(fwd.sel) && (!(fwd.wr && fwd.rd))) // R13
		else $error("more than one module select");

	// read data and forwarded strobes stand one cycle only
	rdata_idle_zero_a: assert property (!bus.rd |=> rdata == '0) // R1
		else $error("read data present without a read");
	fwd_idle_quiet_a: assert property (!bus.wr && !bus.rd |=> (fwd.sel == '0) && !fwd.wr && !fwd.rd) // R13
		else $error("select raised without a bus access");
	own_no_fwd_a: assert property ((bus.rd || bus.wr) && own_hit |=> fwd.sel == '0) // R13
		else $error("own register access forwarded to a window");

	// part id bytes are never written through
	part_id_no_fwd_a: assert property (bus.wr && ((bus.addr == pwd_pkg::PART_ID_HIGH_OFS) ||
		(bus.addr == pwd_pkg::PART_ID_LOW_OFS)) |=> !fwd.wr && (fwd.sel == '0)) // R2
		else $error("part id write forwarded");

	// windows outside the serial channels, per die
	iic_large_a: assert property ((bus.rd || bus.wr) && pwd_pkg::in_range(bus.addr, 11'h0b0, 11'h0b7)
		|=> fwd.sel[pwd_pkg::WIN_IIC1] == $past(die == pwd_pkg::PWD_DIE_LARGE)) // R13
		else $error("first bus window decode wrong for die");
	net_mid_a: assert property ((bus.rd || bus.wr) && pwd_pkg::in_range(bus.addr, 11'h180, 11'h1ff)
		|=> (fwd.sel[pwd_pkg::WIN_NET1] || fwd.sel[pwd_pkg::WIN_NET2]) == $past(die != pwd_pkg::PWD_DIE_SMALL)) // R13
		else $error("network windows decode wrong for die");
	net_large_a: assert property ((bus.rd || bus.wr) && pwd_pkg::in_range(bus.addr, 11'h200, 11'h23f)
		|=> fwd.sel[pwd_pkg::WIN_NET3] == $past(die == pwd_pkg::PWD_DIE_LARGE)) // R13
		else $error("third network window decode wrong for die");
	port_integ_read_a: assert property (bus.rd && pwd_pkg::in_range(bus.addr, 11'h240, 11'h27f)
		|=> fwd.rd && fwd.sel[pwd_pkg::WIN_PORT_INTEG] &&
		(rdata == $past(periph_rdata[pwd_pkg::WIN_PORT_INTEG]))) // R9
		else $error("port integration read not passed through");

	// converter windows and pad routing
	first_conv_window_a: assert property ((bus.rd || bus.wr) && pwd_pkg::in_range(bus.addr, 11'h2c0, 11'h2df)
		|=> fwd.sel[pwd_pkg::WIN_FIRST_CONV] == $past(dual)) // R10
		else $error("first converter window decode wrong for die");
	first_conv_absent_a: assert property (die_valid && !dual && bus.rd &&
		pwd_pkg::in_range(bus.addr, 11'h2c0, 11'h2df) |=> (rdata == '0) && !fwd.rd) // R11
		else $error("absent first converter answered a read");
	first_pad_range_a: assert property (first_conv_pad <= 5'h07) // R10
		else $error("first converter pad above seven");
	single_first_idle_a: assert property (die_valid && !dual |=> first_conv_pad == 5'h00) // R11
		else $error("first converter stepping on single converter die");
	second_pad_upper_a: assert property (die_valid && dual |=> (second_conv_pad >= 5'h08) &&
		(second_conv_pad <= 5'h17)) // R10
		else $error("second converter pad outside upper pads");
	wrap_range_a: assert property (conv_cfg[pwd_pkg::CFG_WRAP_BIT] |-> second_ch <= 4'h7) // R3
		else $error("wrapped sequence above channel seven");
	cfg_restart_a: assert property (cfg_wr |=> second_ch == 4'h0) // R3
		else $error("config write did not restart the sequence");
	cfg_mask_a: assert property (conv_cfg[pwd_pkg::DATA_W-1:1] == '0) // R3
		else $error("unused config bits set");

	part_id_read_c: cover property (bus.rd && (bus.addr == pwd_pkg::PART_ID_HIGH_OFS) ##1 bus.rd &&
		(bus.addr == pwd_pkg::PART_ID_LOW_OFS));
	wrap_event_c: cover property (conv_cfg[pwd_pkg::CFG_WRAP_BIT] && second_conv_step && (second_ch == 4'h7));
	unalloc_write_c: cover property (bus.wr && (hit == '0) && !own_hit);
	periph_read_c: cover property (bus.rd && hit[pwd_pkg::WIN_PORT_INTEG]);
	status_read_c: cover property (bus.rd && (bus.addr == pwd_pkg::DECODE_STAT_OFS));

endmodule // pwd_decode

// >>> rtl/pwd_pkg.sv
// register-space decoder package: window table, own register offsets, carriers, helper functions
// assumes an 11-bit byte-addressed register space and an 8-bit processor data path
package pwd_pkg;

	localparam int ADDR_W  = 11;
	localparam int DATA_W  = 8;
	localparam int NUM_WIN = 11;
	localparam int OFS_W   = 6;
	localparam int CH_W    = 4;
	localparam int PAD_W   = 5;

	// die variants, gray spaced
	typedef enum logic [1:0] {
		PWD_DIE_LARGE = 2'b00,
		PWD_DIE_MID   = 2'b01,
		PWD_DIE_SMALL = 2'b11
	} pwd_die_t;

	// window indices
	localparam int WIN_IIC1       = 0;
	localparam int WIN_ASYNC3     = 1;
	localparam int WIN_ASYNC4     = 2;
	localparam int WIN_SYNC3      = 3;
	localparam int WIN_ASYNC5     = 4;
	localparam int WIN_ASYNC6     = 5;
	localparam int WIN_NET1       = 6;
	localparam int WIN_NET2       = 7;
	localparam int WIN_NET3       = 8;
	localparam int WIN_PORT_INTEG = 9;
	localparam int WIN_FIRST_CONV = 10;

	localparam logic [ADDR_W-1:0] WIN_LO [NUM_WIN] = '{
		11'h0b0, 11'h0b8, 11'h0c0, 11'h0f8, 11'h130, 11'h138,
		11'h180, 11'h1c0, 11'h200, 11'h240, 11'h2c0
	};
	localparam logic [ADDR_W-1:0] WIN_HI [NUM_WIN] = '{
		11'h0b7, 11'h0bf, 11'h0c7, 11'h0ff, 11'h137, 11'h13f,
		11'h1bf, 11'h1ff, 11'h23f, 11'h27f, 11'h2df
	};
	// presence per die: bit0 largest, bit1 middle, bit2 smallest
	localparam logic [2:0] WIN_DIES [NUM_WIN] = '{
		3'h1, 3'h3, 3'h1, 3'h3, 3'h3, 3'h1,
		3'h3, 3'h3, 3'h1, 3'h7, 3'h3
	};

	// own registers
	localparam logic [ADDR_W-1:0] PART_ID_HIGH_OFS = 11'h01a;
	localparam logic [ADDR_W-1:0] PART_ID_LOW_OFS  = 11'h01b;
	localparam logic [ADDR_W-1:0] CONV_CFG_OFS     = 11'h7f0;
	localparam logic [ADDR_W-1:0] DECODE_STAT_OFS  = 11'h7f1;
	localparam logic [DATA_W-1:0] CONV_CFG_RESET   = 8'h00;
	localparam logic [DATA_W-1:0] CONV_CFG_MASK    = 8'h01;
	localparam int                CFG_WRAP_BIT     = 0;

	// converter channel routing
	localparam logic [CH_W-1:0]  WRAP_LAST_CH     = 4'h7;
	localparam logic [CH_W-1:0]  FULL_LAST_CH     = 4'hf;
	localparam logic [CH_W-1:0]  FIRST_LAST_CH    = 4'h7;
	localparam logic [PAD_W-1:0] SECOND_BASE_DUAL = 5'h08;
	localparam logic [PAD_W-1:0] SECOND_BASE_ONE  = 5'h00;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} pwd_req_t;

	typedef struct packed {
		logic [NUM_WIN-1:0] sel;
		logic [OFS_W-1:0]   offset;
		logic [DATA_W-1:0]  wdata;
		logic               wr;
		logic               rd;
	} pwd_fwd_t;

	function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
		input logic [ADDR_W-1:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	function automatic logic die_has(input logic [2:0] m, input pwd_die_t d);
		logic r;
		r = 1'b0;
		case (d)
			PWD_DIE_LARGE: r = m[0];
			PWD_DIE_MID:   r = m[1];
			PWD_DIE_SMALL: r = m[2];
			default:       r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [CH_W-1:0] next_ch(input logic [CH_W-1:0] ch, input logic [CH_W-1:0] last);
		return (ch >= last) ? '0 : CH_W'(ch + 4'h1);
	endfunction

endpackage

// >>> rtl/pwd_window_match.sv
// window match: one hit bit for each peripheral window populated on the given die
// assumes a stable die code and a byte address from the processor bus
`timescale 1ns/1ps
module pwd_window_match (
	input  logic [pwd_pkg::ADDR_W-1:0]  addr,
	input  pwd_pkg::pwd_die_t           die,
	output logic [pwd_pkg::NUM_WIN-1:0] hit
);

	always_comb begin
		hit = '0;
		for (int i = 0; i < pwd_pkg::NUM_WIN; i++) begin
			// windows never overlap, so at most one bit is set
			hit[i] = pwd_pkg::in_range(addr, pwd_pkg::WIN_LO[i], pwd_pkg::WIN_HI[i]) &&
				pwd_pkg::die_has(pwd_pkg::WIN_DIES[i], die); // R4 R5 R6 R7 R8 R9 R13
		end
	end

endmodule // pwd_window_match

// >>> verification/pwd_bus_master.sv
// bus master model: byte writes and reads on the register port of the decoder
// assumes callers enter its tasks right after a rising clock edge
`timescale 1ns/1ps
module pwd_bus_master (
	input  wire logic        clk,
	output pwd_pkg::pwd_req_t bus
);
	initial bus = '0;

	// one strobe, held until the sampling edge; reserved places only when a test asks
	task automatic access(input logic w, input logic [10:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk);
	endtask

	// released lines show the inverse of the last value
	task automatic idle();
		bus <= '{addr: ~bus.addr, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b0};
		@(posedge clk);
	endtask
endmodule // pwd_bus_master

// >>> verification/peripheral_window_decode_tb.sv
// testbench: window selects, own registers and converter routing on all three dies
// assumes the bus master model and the decoder package
`timescale 1ns/1ps
module peripheral_window_decode_tb;
	localparam logic [15:0] IDS   [3]  = '{16'h3c01, 16'h3c02, 16'h3c03}; // arbitrary values
	localparam logic [1:0]  STRAP [3]  = '{2'b00, 2'b01, 2'b11};
	localparam logic [10:0] LO    [11] = '{11'h0b0, 11'h0b8, 11'h0c0, 11'h0f8, 11'h130, 11'h138,
		11'h180, 11'h1c0, 11'h200, 11'h240, 11'h2c0};
	localparam int          SZ    [11] = '{8, 8, 8, 8, 8, 8, 64, 64, 64, 64, 32};
	localparam logic [2:0]  DM    [11] = '{3'h1, 3'h3, 3'h1, 3'h3, 3'h3, 3'h1, 3'h3, 3'h3, 3'h1, 3'h7, 3'h3};

	logic                                             clk;
	logic                                             rst_n;
	logic                                             step1;
	logic                                             step2;
	logic                                             wrap;
	logic                                             st_d;
	logic [1:0]                                       die_strap;
	logic [pwd_pkg::NUM_WIN-1:0][pwd_pkg::DATA_W-1:0] prd;
	pwd_pkg::pwd_req_t                                bus;
	pwd_pkg::pwd_fwd_t                                fwd;
	logic [7:0]                                       rdata;
	logic                                             first_en;
	logic [4:0]                                       pad1;
	logic [4:0]                                       pad2;
	logic [1:0]                                       die_code;
	logic [34:0]                                      notes [$];
	logic [15:0]                                      rnd = 16'h7366;
	int                                               n_errors = 0;
	int                                               tests_run = 0;
	int                                               cycles = 0;

	pwd_bus_master m (.clk(clk), .bus(bus));

	pwd_decode #(.ID_LARGE(IDS[0]), .ID_MID(IDS[1]), .ID_SMALL(IDS[2])) dut (
		.clk(clk), .rst_n(rst_n), .die_strap(die_strap), .bus(bus), .periph_rdata(prd),
		.first_conv_step(step1), .second_conv_step(step2), .rdata(rdata), .fwd(fwd),
		.first_conv_en(first_en), .first_conv_pad(pad1), .second_conv_pad(pad2), .die_code(die_code)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic close_out();
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [26:0] got, input logic [26:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// note the expected select, strobe, offset and read data, then issue the access
	task automatic op(input int d, input logic w, input logic [10:0] a, input logic [7:0] dat);
		logic [10:0] sel;
		logic [5:0]  ofs;
		logic [7:0]  r;
		sel = '0;
		ofs = '0;
		r = '0;
		for (int i = 0; i < 11; i++)
			if (a >= LO[i] && a < LO[i] + SZ[i] && DM[i][d]) begin
				sel[i] = 1'b1;
				ofs = 6'(a - LO[i]);
				r = prd[i];
			end
		if (a == 11'h01a || a == 11'h01b)
			r = a[0] ? IDS[d][7:0] : IDS[d][15:8];
		if (a == 11'h7f0)
			r = {7'h00, wrap};
		// status is read only after a config write with no steps since, so the channel is zero
		if (a == 11'h7f1)
			r = {4'h0, 1'b0, d < 2, STRAP[d]};
		notes.push_back({dat, sel, w & |sel, !w & |sel, ofs, w ? 8'h00 : r});
		m.access(w, a, dat);
	endtask

	// hold a step input for n edges, checking the pad index after each
	task automatic steps(input int n, input logic two, input int d);
		logic [4:0] e;
		if (two) step2 <= 1'b1;
		else step1 <= 1'b1;
		for (int k = 1; k <= n; k++) begin
			@(posedge clk);
			if (k == n) begin
				step1 <= 1'b0;
				step2 <= 1'b0;
			end
			#1;
			if (two) e = 5'((d < 2 ? 8 : 0) + (k % (wrap ? 8 : 16)));
			else e = 5'(d < 2 ? k % 8 : 0);
			chk(27'(two ? pad2 : pad1), 27'(e));
		end
		@(posedge clk);
	endtask

	// result watcher: one note per strobe, compared in the following cycle
	always @(posedge clk or negedge rst_n)
		if (!rst_n) st_d <= 1'b0;
		else st_d <= bus.wr | bus.rd;

	always @(negedge clk) begin
		logic [34:0] e;
		if (st_d) begin
			e = notes.pop_front();
			chk({fwd.sel, fwd.wr, fwd.rd, (e[26:16] == 0) ? e[13:8] : fwd.offset, rdata}, e[26:0]);
			chk(27'(fwd.wdata), 27'(e[34:27]));
		end
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end

	initial begin
		rst_n = 1'b0;
		die_strap = 2'b00;
		step1 = 1'b0;
		step2 = 1'b0;
		prd = '0;
		wrap = 1'b0;
		for (int d = 0; d < 3; d++) begin
			@(posedge clk);
			rst_n <= 1'b0;
			die_strap <= STRAP[d];
			wrap = 1'b0;
			for (int i = 0; i < 11; i++) begin
				rnd = lfsr(rnd);
				prd[i] <= rnd[7:0];
			end
			repeat (6) @(posedge clk);
			rst_n <= 1'b1;
			@(posedge clk);
			for (int i = 0; i < 11; i++) begin
				rnd = lfsr(rnd);
				op(d, 1'b1, 11'(LO[i] + SZ[i] - 1), rnd[15:8]);
				op(d, 1'b0, LO[i], 8'h00);
			end
			op(d, 1'b1, 11'h01a, 8'hff);
			op(d, 1'b1, 11'h01b, 8'hff);
			op(d, 1'b0, 11'h01b, 8'h00);
			op(d, 1'b0, 11'h01a, 8'h00);
			op(d, 1'b0, 11'h01b, 8'h00);
			op(d, 1'b1, 11'h0a8, 8'h55);
			op(d, 1'b0, 11'h0a8, 8'h00);
			op(d, 1'b0, 11'h300, 8'h00);
			m.idle();
			#1;
			chk(27'(die_code), 27'(STRAP[d]));
			chk(27'(first_en), 27'(d < 2));
			chk(27'(pad2), 27'(d < 2 ? 8 : 0));
			@(posedge clk);
			steps(17, 1'b1, d);
			op(d, 1'b1, 11'h7f0, 8'hff);
			wrap = 1'b1;
			op(d, 1'b0, 11'h7f0, 8'h00);
			op(d, 1'b1, 11'h7f1, 8'hff);
			op(d, 1'b0, 11'h7f1, 8'h00);
			m.idle();
			steps(9, 1'b1, d);
			steps(9, 1'b0, d);
			$display("die %0d tests done", d);
		end
		repeat (2) @(posedge clk);
		close_out();
	end
endmodule // peripheral_window_decode_tb
